// ===== jdra_monitor.sv
/*
 * Port checker for jdra_top.
 * Assumes it is bound onto jdra_top and sees only its ports.
 */
module jdra_monitor (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic jtag_rst_i,
    input wire logic cpu_reset_i,
    input wire logic tdo_o,
    input wire logic tdo_oe_o,
    input wire logic external_debug_enable_o,
    input wire logic internal_debug_enable_o,
    input wire logic freeze_timers_o
);
    // ----------------------------------------------------
    // age of the last reset; the clear lags by two domains
    // ----------------------------------------------------
    logic [5:0] since_rst;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || jtag_rst_i) begin
            since_rst <= 6'h00;
        end else if (since_rst != 6'h3F) begin
            since_rst <= since_rst + 6'h01;
        end
    end
    property p_tdo_idle;
        @(posedge tck_i) disable iff (sys_rst_i || jtag_rst_i)
        !tdo_oe_o |-> !tdo_o;
    endproperty
    a_tdo_idle: assert property (p_tdo_idle)
        else $error("tdo not low outside shift");
    property p_oe_rise;
        @(posedge tck_i) disable iff (sys_rst_i || jtag_rst_i)
        $rose(tdo_oe_o) |-> !$past(tms_i);
    endproperty
    a_oe_rise: assert property (p_oe_rise)
        else $error("shift entered without tms low");
    property p_oe_fall;
        @(posedge tck_i) disable iff (sys_rst_i || jtag_rst_i)
        $fell(tdo_oe_o) |-> $past(tms_i);
    endproperty
    a_oe_fall: assert property (p_oe_fall)
        else $error("shift left without tms high");
    property p_tms_ones;
        @(posedge tck_i) disable iff (sys_rst_i || jtag_rst_i)
        tms_i [*3] |-> !tdo_oe_o;
    endproperty
    a_tms_ones: assert property (p_tms_ones)
        else $error("still shifting after tms ones");
    property p_port_rst_oe;
        @(posedge tck_i) disable iff (sys_rst_i)
        jtag_rst_i [*5] |-> !tdo_oe_o;
    endproperty
    a_port_rst_oe: assert property (p_port_rst_oe)
        else $error("tdo enabled in port reset");
    property p_ext_fall;
        @(posedge clk_i) disable iff (sys_rst_i)
        $fell(external_debug_enable_o) |-> since_rst < 6'h20;
    endproperty
    a_ext_fall: assert property (p_ext_fall)
        else $error("enable lost without port reset");
    property p_cpu_rst;
        @(posedge clk_i) disable iff (sys_rst_i)
        cpu_reset_i [*8] |-> ##[0:12]
            (!internal_debug_enable_o && !freeze_timers_o);
    endproperty
    a_cpu_rst: assert property (p_cpu_rst)
        else $error("processor reset left control bits");
    property p_port_rst;
        @(posedge clk_i) disable iff (sys_rst_i)
        jtag_rst_i [*8] |-> ##[0:12] !external_debug_enable_o;
    endproperty
    a_port_rst: assert property (p_port_rst)
        else $error("port reset left enable set");
    property p_int_gate;
        @(posedge clk_i) disable iff (sys_rst_i)
        $rose(internal_debug_enable_o) |-> external_debug_enable_o;
    endproperty
    a_int_gate: assert property (p_int_gate)
        else $error("control bit set while locked");
endmodule
bind jdra_top jdra_monitor u_jdra_monitor (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .tck_i(tck_i), .tms_i(tms_i),
    .jtag_rst_i(jtag_rst_i), .cpu_reset_i(cpu_reset_i),
    .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
    .external_debug_enable_o(external_debug_enable_o),
    .internal_debug_enable_o(internal_debug_enable_o),
    .freeze_timers_o(freeze_timers_o));

// ===== jdra_pkg.sv
/*
 * Shared constants for the debug register access block: command word
 * layout, register select codes, status word layout, debug control
 * word layout, storage slots and the test controller state type.
 * Assumes a standard four-wire test port with an optional port reset.
 */
// ----------------------------------------------------------------
// Overview of operation
// [R1] codes 24h/25h select data compare one, two
// [R2] 2Ch debug counter, 2Dh read-only history buffer
// [R3] 30h event status, 31h-34h control zero-three
// [R4] 70h-79h select general purpose slots zero-nine
// [R5] 7Ah cache debug control, 7Bh cache data
// [R6] 7Eh enable select; block works without it
// [R7] tool writes: command with direction clear, data
// [R8] read command then data scan returns register
// [R9] most registers denied until external enable set; code gates data compare, debug counter, event status, control one-three, control zero bits 30-0
// [R10] 031h writes control zero, 231h reads it
// [R11] writing 80000000h sets external enable, reads back
// [R12] all scans shift least significant bit first
// [R13] tool starts and ends scans in idle
// [R14] status captured at Capture-IR, shifted Shift-IR
// [R15] status word is ten bits like command
// [R16] read no-register reports clock and debug flags
// [R17] enable cleared by port/power reset only; code also clears it on a control zero write with bit 31 clear
// [R18] control zero layout, reserved bits read zero
// [R19] command: direction, go, exit, seven-bit select
// [R20] writes to read-only register are discarded
// [R21] direction ignored for read-only and bypass
// [R22] reserved codes act as bypass, read zero
// ----------------------------------------------------------------
package jdra_pkg;

    // command word, bit numbers counted from the lsb
    localparam int CMD_W       = 10;
    localparam int CMD_RW_BIT  = 9;
    localparam int CMD_GO_BIT  = 8;
    localparam int CMD_EX_BIT  = 7;
    localparam int RS_W        = 7;
    localparam logic [CMD_W-1:0] CMD_RESET = 10'h07F;

    localparam logic [RS_W-1:0] RS_NOREG  = 7'h11;
    localparam logic [RS_W-1:0] RS_DATA_COMPARE_1   = 7'h24;
    localparam logic [RS_W-1:0] RS_DATA_COMPARE_2   = 7'h25;
    localparam logic [RS_W-1:0] RS_DEBUG_COUNTER  = 7'h2C;
    localparam logic [RS_W-1:0] RS_PCHIST = 7'h2D;
    localparam logic [RS_W-1:0] RS_EVSTAT = 7'h30;
    localparam logic [RS_W-1:0] RS_CTRL0  = 7'h31;
    localparam logic [RS_W-1:0] RS_CTRL1  = 7'h32;
    localparam logic [RS_W-1:0] RS_CTRL3  = 7'h34;
    localparam logic [RS_W-1:0] RS_GPR0   = 7'h70;
    localparam logic [RS_W-1:0] RS_GPR9   = 7'h79;
    localparam logic [RS_W-1:0] RS_CDCTL  = 7'h7A;
    localparam logic [RS_W-1:0] RS_CDDATA = 7'h7B;
    localparam logic [RS_W-1:0] RS_ENABLE = 7'h7E;
    localparam logic [RS_W-1:0] RS_BYPASS = 7'h7F;

    // status word
    localparam int STAT_W         = 10;
    localparam int STAT_MCLK_BIT  = 9;
    localparam int STAT_DEBUG_BIT = 3;
    localparam logic [STAT_W-1:0] STAT_FIXED = 10'h001;

    // data path and debug control zero
    localparam int DR_W        = 32;
    localparam int EDM_BIT     = 31;
    localparam int IDM_BIT     = 30;
    localparam int FT_BIT      = 0;
    localparam logic [DR_W-1:0] CTRL0_RSVD  = 32'h0000_781E;
    localparam logic [DR_W-1:0] CTRL0_EDM   = 32'h8000_0000;
    localparam logic [DR_W-1:0] CTRL0_RESET = 32'h0000_0000;

    // storage slots
    localparam int SLOT_W = 5;
    localparam int NUM_SLOTS = 19;
    localparam logic [SLOT_W-1:0] SLOT_DATA_COMPARE_1   = 5'h00;
    localparam logic [SLOT_W-1:0] SLOT_DATA_COMPARE_2   = 5'h01;
    localparam logic [SLOT_W-1:0] SLOT_DEBUG_COUNTER  = 5'h02;
    localparam logic [SLOT_W-1:0] SLOT_EVSTAT = 5'h03;
    localparam logic [SLOT_W-1:0] SLOT_CTRL1  = 5'h04;
    localparam logic [SLOT_W-1:0] SLOT_GPR0   = 5'h07;
    localparam logic [SLOT_W-1:0] SLOT_CDCTL  = 5'h11;
    localparam logic [SLOT_W-1:0] SLOT_CDDATA = 5'h12;

    typedef enum logic [15:0] {
        TAP_RESET    = 16'h0001,
        TAP_IDLE     = 16'h0002,
        TAP_SEL_DR   = 16'h0004,
        TAP_CAP_DR   = 16'h0008,
        TAP_SHIFT_DR = 16'h0010,
        TAP_EXIT1_DR = 16'h0020,
        TAP_PAUSE_DR = 16'h0040,
        TAP_EXIT2_DR = 16'h0080,
        TAP_UPD_DR   = 16'h0100,
        TAP_SEL_IR   = 16'h0200,
        TAP_CAP_IR   = 16'h0400,
        TAP_SHIFT_IR = 16'h0800,
        TAP_EXIT1_IR = 16'h1000,
        TAP_PAUSE_IR = 16'h2000,
        TAP_EXIT2_IR = 16'h4000,
        TAP_UPD_IR   = 16'h8000
    } jdra_tap_type;

endpackage

// ===== jdra_sync.sv
/*
 * Two-flop level synchroniser, one per bit of a bus.
 * Assumes each bit is an independent level or a toggle.
 */
module jdra_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    // first stage is read by the second stage only
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_i) begin
        meta   <= async_i;
        sync_o <= meta;
    end

endmodule

// ===== jdra_tap_fsm.sv
/*
 * Test access port controller state machine, sixteen states.
 * Assumes tms is stable around the rising edge of the test clock.
 */
module jdra_tap_fsm (
    input  wire logic             tck_i,
    input  wire logic             rst_i,
    input  wire logic             tms_i,
    output jdra_pkg::jdra_tap_type state_o
);
    import jdra_pkg::*;

    jdra_tap_type next_state;

    always_comb begin
        next_state = TAP_RESET;
        unique case (state_o)
            TAP_RESET:    next_state = tms_i ? TAP_RESET : TAP_IDLE;
            TAP_IDLE:     next_state = tms_i ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR:   next_state = tms_i ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR:   next_state = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: next_state = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: next_state = tms_i ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: next_state = tms_i ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: next_state = tms_i ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR:   next_state = tms_i ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR:   next_state = tms_i ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR:   next_state = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: next_state = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: next_state = tms_i ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: next_state = tms_i ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: next_state = tms_i ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR:   next_state = tms_i ? TAP_SEL_DR : TAP_IDLE;
            // a corrupted code falls back to reset
            default:      next_state = TAP_RESET;
        endcase
    end

    always_ff @(posedge tck_i) begin
        if (rst_i) begin
            state_o <= TAP_RESET;
        end else begin
            state_o <= next_state;
        end
    end

endmodule

// ===== jdra_tool.sv
/*
 * Model of the external debug tool on the test port.
 * Assumes the caller starts each scan in Run-Test/Idle.
 */
module jdra_tool (
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    input  wire logic tdo_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------
    // 15 ns test clock, stands low between calls
    // ------------------------------------------
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end
    task automatic step(input logic ms, input logic di, output logic q);
        tms_o = ms;
        tdi_o = di;
        #7.5;
        q = tdo_i;
        tck_o = 1'b1;
        #7.5;
        tck_o = 1'b0;
    endtask
    task automatic run(input logic ms, input int n);
        logic q;
        repeat (n) step(ms, ~tdi_o, q);
    endtask
    task automatic scan(input logic ir, input logic [31:0] din,
                        input int n, output logic [31:0] dout);
        logic q;
        dout = '0;
        step(1'b1, ~tdi_o, q);
        if (ir) step(1'b1, ~tdi_o, q);
        step(1'b0, ~tdi_o, q);
        step(1'b0, ~tdi_o, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, ~tdi_o, q);
        step(1'b0, ~tdi_o, q);
    endtask
endmodule

// ===== jdra_top.sv
/*
 * Debug register access through the test port: command and status
 * scans on the instruction path, register scans on the data path,
 * debug register storage, and the crossings to the system clock.
 * Assumes the test clock runs while any reset is to take effect on
 * the test side, and that the processor holds its history value
 * stable only as long as the system clock samples it.
 */
module jdra_top (
    input  wire logic                       clk_i,
    input  wire logic                       sys_rst_i,
    input  wire logic                       tck_i,
    input  wire logic                       tms_i,
    input  wire logic                       tdi_i,
    input  wire logic                       jtag_rst_i,
    input  wire logic                       cpu_reset_i,
    input  wire logic                       cpu_clock_running_i,
    input  wire logic                       cpu_debug_mode_i,
    input  wire logic [jdra_pkg::DR_W-1:0]  pc_history_i,
    output logic                            tdo_o,
    output logic                            tdo_oe_o,
    output logic                            external_debug_enable_o,
    output logic                            internal_debug_enable_o,
    output logic                            freeze_timers_o
);
    import jdra_pkg::*;

    // ------------------------------------------------------------
    // selection kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        KIND_BYPASS = 2'h0,
        KIND_STORE  = 2'h1,
        KIND_CTRL0  = 2'h2,
        KIND_PC     = 2'h3
    } jdra_kind_type;

    // bit positions of the crossing buses
    localparam int TS_POR   = 0;
    localparam int TS_PRST  = 1;
    localparam int TS_CRST  = 2;
    localparam int TS_MCLK  = 3;
    localparam int TS_DBG   = 4;
    localparam int TS_REQ   = 5;
    localparam int TS_W     = 6;
    localparam int CS_ACK   = 0;
    localparam int CS_EDM   = 1;
    localparam int CS_IDM   = 2;
    localparam int CS_FT    = 3;
    localparam int CS_W     = 4;

    // ------------------------------------------------------------
    // decode functions
    // ------------------------------------------------------------
    function automatic logic is_store(input logic [RS_W-1:0] rs);
        is_store = (rs == RS_DATA_COMPARE_1) || (rs == RS_DATA_COMPARE_2)         // R1
                || (rs == RS_DEBUG_COUNTER)                           // R2
                || (rs == RS_EVSTAT)                          // R3
                || (rs >= RS_CTRL1 && rs <= RS_CTRL3)         // R3
                || (rs >= RS_GPR0 && rs <= RS_GPR9)           // R4
                || (rs == RS_CDCTL) || (rs == RS_CDDATA);     // R5
    endfunction

    // everything not named here, including the enable select, the
    // no-register select and all reserved codes, is a bypass
    function automatic jdra_kind_type sel_kind(
        input logic [RS_W-1:0] rs
    );
        if (rs == RS_CTRL0) begin
            sel_kind = KIND_CTRL0;                            // R3
        end else if (rs == RS_PCHIST) begin
            sel_kind = KIND_PC;                               // R2
        end else if (is_store(rs)) begin
            sel_kind = KIND_STORE;
        end else begin
            sel_kind = KIND_BYPASS;                           // R6 R22
        end
    endfunction

    function automatic logic [SLOT_W-1:0] sel_slot(
        input logic [RS_W-1:0] rs
    );
        logic [RS_W-1:0] ofs;
        ofs = '0;
        if (rs == RS_DATA_COMPARE_2) begin
            sel_slot = SLOT_DATA_COMPARE_2;                             // R1
        end else if (rs == RS_DEBUG_COUNTER) begin
            sel_slot = SLOT_DEBUG_COUNTER;                            // R2
        end else if (rs == RS_EVSTAT) begin
            sel_slot = SLOT_EVSTAT;                           // R3
        end else if (rs >= RS_CTRL1 && rs <= RS_CTRL3) begin
            ofs = rs - RS_CTRL1;
            sel_slot = SLOT_CTRL1 + ofs[SLOT_W-1:0];          // R3
        end else if (rs >= RS_GPR0 && rs <= RS_GPR9) begin
            ofs = rs - RS_GPR0;
            sel_slot = SLOT_GPR0 + ofs[SLOT_W-1:0];           // R4
        end else if (rs == RS_CDCTL) begin
            sel_slot = SLOT_CDCTL;                            // R5
        end else if (rs == RS_CDDATA) begin
            sel_slot = SLOT_CDDATA;                           // R5
        end else begin
            sel_slot = SLOT_DATA_COMPARE_1;
        end
    endfunction

    // registers that need the external enable before any access
    function automatic logic sel_gated(input logic [RS_W-1:0] rs);
        sel_gated = (rs == RS_DATA_COMPARE_1) || (rs == RS_DATA_COMPARE_2)
                 || (rs == RS_DEBUG_COUNTER) || (rs == RS_EVSTAT)
                 || (rs >= RS_CTRL1 && rs <= RS_CTRL3);       // R9
    endfunction

    // ------------------------------------------------------------
    // crossings into the test clock domain
    // ------------------------------------------------------------
    logic                req_tgl;
    logic [DR_W-1:0]     pc_hold;
    logic [TS_W-1:0]     tck_async;
    logic [TS_W-1:0]     tck_sync;

    assign tck_async = {req_tgl, cpu_debug_mode_i,
                        cpu_clock_running_i, cpu_reset_i,
                        jtag_rst_i, sys_rst_i};

    jdra_sync #(
        .WIDTH   (TS_W)
    ) u_tck_sync (
        .clk_i   (tck_i),
        .async_i (tck_async),
        .sync_o  (tck_sync)
    );

    wire por_tck  = tck_sync[TS_POR];
    wire port_rst = por_tck | tck_sync[TS_PRST];
    wire cpu_rst  = por_tck | tck_sync[TS_CRST];

    // ------------------------------------------------------------
    // test controller
    // ------------------------------------------------------------
    jdra_tap_type state;

    jdra_tap_fsm u_tap (
        .tck_i   (tck_i),
        .rst_i   (port_rst),
        .tms_i   (tms_i),
        .state_o (state)
    );

    wire st_reset    = (state == TAP_RESET);
    wire st_cap_ir   = (state == TAP_CAP_IR);
    wire st_shift_ir = (state == TAP_SHIFT_IR);
    wire st_upd_ir   = (state == TAP_UPD_IR);
    wire st_cap_dr   = (state == TAP_CAP_DR);
    wire st_shift_dr = (state == TAP_SHIFT_DR);
    wire st_upd_dr   = (state == TAP_UPD_DR);

    // ------------------------------------------------------------
    // command, status and data shift paths
    // ------------------------------------------------------------
    logic [CMD_W-1:0]    cmd;
    logic [CMD_W-1:0]    ir_sr;
    logic [DR_W-1:0]     dr_sr;
    logic                ext_en;
    logic [EDM_BIT-1:0]  ctrl0_rest;
    logic [DR_W-1:0]     store [NUM_SLOTS];
    logic [DR_W-1:0]     pc_shadow;
    logic                ack_tgl;

    // go and exit only steer the processor, which sits outside
    wire [RS_W-1:0]  rs      = cmd[RS_W-1:0];                 // R19
    wire             cmd_rd  = cmd[CMD_RW_BIT];               // R19
    wire jdra_kind_type kind = sel_kind(rs);
    wire [SLOT_W-1:0] slot   = sel_slot(rs);
    wire             allowed = !sel_gated(rs) || ext_en;      // R9

    // only the enable bit is visible before it is set
    wire [DR_W-1:0]  ctrl0_full = {ext_en, ctrl0_rest} & ~CTRL0_RSVD;
    wire [DR_W-1:0]  ctrl0_view = ext_en ? ctrl0_full
                                         : (ctrl0_full & CTRL0_EDM);
    wire [DR_W-1:0]  store_word = store[slot];

    wire [DR_W-1:0]  read_val =
        (kind == KIND_CTRL0) ? ctrl0_view :                   // R10 R11
        (kind == KIND_PC)    ? pc_shadow  :
        (kind == KIND_STORE) ? store_word : '0;               // R22

    // read-only history is read whatever the direction says
    wire             is_read = cmd_rd || (kind == KIND_PC);   // R21
    wire [DR_W-1:0]  cap_val = (is_read && allowed) ? read_val
                                                    : '0;     // R8 R9

    wire             wr_ok  = st_upd_dr && !cmd_rd && allowed;
    wire             ctrl0_we = wr_ok && (kind == KIND_CTRL0); // R10
    wire             store_we = wr_ok && (kind == KIND_STORE); // R7 R20

    wire [DR_W-1:0]  ctrl0_new = dr_sr & ~CTRL0_RSVD;         // R18

    wire [STAT_W-1:0] status =
        STAT_FIXED
        | ({{(STAT_W-1){1'b0}}, tck_sync[TS_MCLK]} << STAT_MCLK_BIT)
        | ({{(STAT_W-1){1'b0}}, tck_sync[TS_DBG]}  << STAT_DEBUG_BIT);

    always_ff @(posedge tck_i) begin
        if (st_cap_ir) begin
            ir_sr <= status;                                  // R14 R15 R16
        end else if (st_shift_ir) begin
            ir_sr <= {tdi_i, ir_sr[CMD_W-1:1]};               // R12
        end
    end

    always_ff @(posedge tck_i) begin
        if (port_rst || st_reset) begin
            cmd <= CMD_RESET;
        end else if (st_upd_ir) begin
            cmd <= ir_sr;                                     // R19
        end
    end

    always_ff @(posedge tck_i) begin
        if (st_cap_dr) begin
            dr_sr <= cap_val;                                 // R8
        end else if (st_shift_dr) begin
            dr_sr <= {tdi_i, dr_sr[DR_W-1:1]};                // R12
        end
    end

    // ------------------------------------------------------------
    // debug control zero
    // ------------------------------------------------------------
    // the enable survives the processor reset pin on purpose
    always_ff @(posedge tck_i) begin
        if (port_rst) begin
            ext_en <= CTRL0_RESET[EDM_BIT];                   // R17
        end else if (ctrl0_we) begin
            ext_en <= dr_sr[EDM_BIT];                         // R11
        end
    end

    always_ff @(posedge tck_i) begin
        if (cpu_rst) begin
            ctrl0_rest <= CTRL0_RESET[EDM_BIT-1:0];           // R17
        end else if (ctrl0_we && ext_en) begin
            ctrl0_rest <= ctrl0_new[EDM_BIT-1:0];             // R9 R18
        end
    end

    // ------------------------------------------------------------
    // general debug register storage
    // ------------------------------------------------------------
    always_ff @(posedge tck_i) begin
        if (por_tck) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                store[i] <= '0;
            end
        end else if (store_we) begin
            store[slot] <= dr_sr;                             // R7
        end
    end

    // history word handshake: the hold word is stable while pending
    always_ff @(posedge tck_i) begin
        if (por_tck) begin
            pc_shadow <= '0;
            ack_tgl   <= 1'b0;
        end else if (tck_sync[TS_REQ] != ack_tgl) begin
            pc_shadow <= pc_hold;
            ack_tgl   <= tck_sync[TS_REQ];
        end
    end

    // ------------------------------------------------------------
    // test data output, changed on the falling edge
    // ------------------------------------------------------------
    wire next_tdo = st_shift_ir ? ir_sr[0] :
                    st_shift_dr ? dr_sr[0] : 1'b0;            // R12 R14

    always_ff @(negedge tck_i) begin
        if (port_rst) begin
            tdo_o    <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else begin
            tdo_o    <= next_tdo;
            tdo_oe_o <= st_shift_ir || st_shift_dr;
        end
    end

    // ------------------------------------------------------------
    // system clock side
    // ------------------------------------------------------------
    logic [CS_W-1:0]     clk_async;
    logic [CS_W-1:0]     clk_sync;

    assign clk_async = {ctrl0_rest[FT_BIT], ctrl0_rest[IDM_BIT],
                        ext_en, ack_tgl};

    jdra_sync #(
        .WIDTH   (CS_W)
    ) u_clk_sync (
        .clk_i   (clk_i),
        .async_i (clk_async),
        .sync_o  (clk_sync)
    );

    // a new sample is taken only after the last one was acknowledged
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            req_tgl <= 1'b0;
            pc_hold <= '0;
        end else if (clk_sync[CS_ACK] == req_tgl) begin
            req_tgl <= ~req_tgl;
            pc_hold <= pc_history_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            external_debug_enable_o <= 1'b0;
            internal_debug_enable_o <= 1'b0;
            freeze_timers_o         <= 1'b0;
        end else begin
            external_debug_enable_o <= clk_sync[CS_EDM];
            internal_debug_enable_o <= clk_sync[CS_IDM];
            freeze_timers_o         <= clk_sync[CS_FT];
        end
    end

endmodule

// ===== tb_top.sv
/*
 * Testbench for jdra_top driven through the test port.
 * Assumes jdra_tool models the debug tool.
 */
`define chk(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    n_fail++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import jdra_pkg::*;
    logic        clk_i = 1'b0;
    logic        sys_rst_i, jtag_rst_i, cpu_reset_i, clk_run, dbg;
    logic        tck, tms, tdi, tdo, ext_en, int_en, frz;
    logic [31:0] pc_hist, q;
    int          n_fail = 0, total_checks = 0, cycles = 0;
    logic [6:0]  rw_rs [19] = '{7'h24, 7'h25, 7'h2C, 7'h30, 7'h32,
        7'h33, 7'h34, 7'h70, 7'h71, 7'h72, 7'h73, 7'h74, 7'h75,
        7'h76, 7'h77, 7'h78, 7'h79, 7'h7A, 7'h7B};
    logic [6:0]  byp [9] = '{7'h11, 7'h26, 7'h2F, 7'h35, 7'h5F,
        7'h7C, 7'h7D, 7'h7E, 7'h7F};
    always #5 clk_i = ~clk_i;
    jdra_tool u_jdra_tool (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
        .tdo_i(tdo));
    jdra_top u_jdra_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .jtag_rst_i(jtag_rst_i),
        .cpu_reset_i(cpu_reset_i), .cpu_clock_running_i(clk_run),
        .cpu_debug_mode_i(dbg), .pc_history_i(pc_hist), .tdo_o(tdo),
        .tdo_oe_o(), .external_debug_enable_o(ext_en),
        .internal_debug_enable_o(int_en), .freeze_timers_o(frz));
    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // hang guard, well above the expected run length
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic wr(input logic [6:0] rs, input logic [31:0] v);
        u_jdra_tool.scan(1'b1, {25'h0, rs}, 10, q);
        u_jdra_tool.scan(1'b0, v, 32, q);
    endtask
    task automatic rd(input logic [6:0] rs, input logic [31:0] e,
                      input string nm);
        u_jdra_tool.scan(1'b1, {22'h0, 3'h4, rs}, 10, q);
        u_jdra_tool.scan(1'b0, 32'h0, 32, q);
        `chk(nm, e, q)
    endtask
    // reset pins cross into tck, so the test clock must run
    task automatic pulse_rst(input bit port);
        @(posedge clk_i);
        if (port) jtag_rst_i <= 1'b1;
        else cpu_reset_i <= 1'b1;
        u_jdra_tool.run(1'b0, 8);
        @(posedge clk_i);
        jtag_rst_i <= 1'b0;
        cpu_reset_i <= 1'b0;
        u_jdra_tool.run(1'b1, 5);
        u_jdra_tool.run(1'b0, 1);
        repeat (20) @(posedge clk_i);
    endtask
    initial begin
        {sys_rst_i, jtag_rst_i, cpu_reset_i, clk_run, dbg} = 5'b10011;
        pc_hist = 32'hA5C3_5A3C;
        u_jdra_tool.run(1'b1, 8);
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        u_jdra_tool.run(1'b1, 5);
        u_jdra_tool.run(1'b0, 1);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            {clk_run, dbg} <= k[1:0];
            u_jdra_tool.run(1'b0, 4);
            u_jdra_tool.scan(1'b1, 32'h211, 10, q);
            `chk("status", {22'h0, k[1], 5'h0, k[0], 3'h1}, q)
        end
        wr(RS_DATA_COMPARE_1, 32'h1234_5678);
        rd(RS_DATA_COMPARE_1, 32'h0, "data_compare_1 locked");
        wr(RS_CTRL0, 32'hFFFF_FFFF);
        repeat (20) @(posedge clk_i);
        `chk("int en locked", 1'b0, int_en)
        rd(RS_CTRL0, CTRL0_EDM, "ctrl0 first");
        wr(RS_CTRL0, 32'h8000_0000);
        rd(RS_CTRL0, 32'h8000_0000, "ctrl0");
        wr(RS_CTRL0, 32'hFFFF_FFFF);
        rd(RS_CTRL0, ~CTRL0_RSVD, "ctrl0 full");
        repeat (20) @(posedge clk_i);
        `chk("enables", 3'h7, {ext_en, int_en, frz})
        foreach (rw_rs[i]) wr(rw_rs[i], {rw_rs[i], ~rw_rs[i], 18'h25A5A});
        foreach (rw_rs[i]) rd(rw_rs[i], {rw_rs[i], ~rw_rs[i], 18'h25A5A},
            "storage");
        wr(RS_PCHIST, 32'hFFFF_FFFF);
        `chk("history", pc_hist, q)
        rd(RS_PCHIST, pc_hist, "history");
        foreach (byp[i]) begin
            wr(byp[i], 32'hFFFF_FFFF);
            rd(byp[i], 32'h0, "bypass");
        end
        pulse_rst(1'b0);
        `chk("cpu rst", 2'b10, {ext_en, int_en})
        rd(RS_CTRL0, CTRL0_EDM, "ctrl0 cpu rst");
        pulse_rst(1'b1);
        `chk("port rst", 1'b0, ext_en)
        rd(RS_DATA_COMPARE_1, 32'h0, "data_compare_1 relocked");
        end_of_test();
    end
endmodule
